// ===== rtl/udb_pkg.sv
// Shared constants and state codes for the burst handshake ends.
// Assumes both ends run on one 10 MHz core clock of their own.
package udb_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int ENV_NS = 20;
    localparam int ZAH_NS = 20;
    // Least times round up, never below one cycle
    localparam int ENV_RAW = (ENV_NS + CLK_NS - 1) / CLK_NS;
    localparam int ZAH_RAW = (ZAH_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] ENV_CNT = 4'((ENV_RAW < 1) ? 1 : ENV_RAW);
    localparam logic [3:0] ZAH_CNT = 4'((ZAH_RAW < 1) ? 1 : ZAH_RAW);
    // Core cycles between data load and strobe edge, and from an edge to the next load
    localparam logic [3:0] TICK_CNT = 4'h6;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int DW = 16;
    localparam logic [DW-1:0] BUS_IDLE = 16'h0000;
    localparam logic [DW-1:0] BUS_PULL = 16'hFFFF;
    localparam logic STRB_RST = 1'b1;

    // ------------------------------------------------------------
    // State codes
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        DS_IDLE  = 7'h01,
        DS_REQ   = 7'h02,
        DS_ACKD  = 7'h04,
        DS_LOAD  = 7'h08,
        DS_EDGE  = 7'h10,
        DS_PAUSE = 7'h20,
        DS_END   = 7'h40
    } udb_dev_st_t;

    typedef enum logic [6:0] {
        HS_IDLE = 7'h01,
        HS_ENV  = 7'h02,
        HS_RECV = 7'h04,
        HS_TERM = 7'h08,
        HS_ZAH  = 7'h10,
        HS_CRC  = 7'h20,
        HS_REL  = 7'h40
    } udb_host_st_t;

endpackage : udb_pkg

// ===== rtl/udb_if.sv
// Link wires between the host end and the device end.
// Assumes the bench joins one instance to both ends; the data bus is
// resolved here from both output enables.
`timescale 1ns/1ps
interface udb_if;
    logic dmarq;
    logic dmack_n;
    logic stop;
    logic hdmardy_n;
    logic dstrobe;
    logic [udb_pkg::DW-1:0] host_dd;
    logic host_dd_oe_n;
    logic [udb_pkg::DW-1:0] dev_dd;
    logic dev_dd_oe_n;
    logic [udb_pkg::DW-1:0] dd;

    // Bus level from the enables, pulled high when nobody drives
    assign dd = !host_dd_oe_n ? host_dd : (!dev_dd_oe_n ? dev_dd : udb_pkg::BUS_PULL);

    modport host (
        output dmack_n,
        output stop,
        output hdmardy_n,
        output host_dd,
        output host_dd_oe_n,
        input dmarq,
        input dstrobe,
        input dd
    );

    modport dev (
        output dmarq,
        output dstrobe,
        output dev_dd,
        output dev_dd_oe_n,
        input dmack_n,
        input stop,
        input hdmardy_n,
        input dd
    );
endinterface : udb_if

// ===== rtl/udb_dev.sv
// Device end of a data-in burst: requests, qualifies the host, sends words.
// Assumes the host end on the far side of udb_if and a 10 MHz core clock.
// Function
// - Host releases data bus when asserting acknowledge.
// - Device floats bus with request negation.
// - Host waits before driving the CRC word.
// - Device drives bus after stop/ready qualify.
// - Stop negated plus ready proves burst mode.
// - Host waits 20 ns before control changes.
// - Host counts cycles from acknowledge onward.
// - Host may wait indefinitely on device events.
// - After pause, at most one more strobe.
// - Synchronise ready, suppress next scheduled strobe.
// - Longer synchroniser allowed if strobes stay held.
// - Control lines settled before acknowledge negation.
// - First word driven within 2.5 cycles; the device here drives the bus 5 core cycles after stop/ready change.
`timescale 1ns/1ps
module udb_dev (
    input wire logic core_clk,
    input wire logic reset_n,
    udb_if.dev link,
    input wire logic start,
    input wire logic [udb_pkg::DW-1:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    output logic busy,
    output logic [7:0] words_sent
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        udb_pkg::udb_dev_st_t st;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] f;
        logic [3:0] tick;
        logic dmarq;
        logic strobe;
        logic oe_n;
        logic [udb_pkg::DW-1:0] dd;
        logic pend;
        logic last;
        logic [7:0] cnt;
    } udb_dev_state_t;

    udb_dev_state_t q;
    udb_dev_state_t d;

    // Filtered host lines: bit 2 acknowledge, bit 1 stop, bit 0 ready
    logic ack_seen;
    logic stop_seen;
    logic paused;
    logic tick_hit;

    assign ack_seen = !q.f[2];
    assign stop_seen = q.f[1];
    assign paused = q.f[0];
    assign tick_hit = (q.tick == 4'h0);

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Word taken only on a load tick while the host accepts
    assign tx_ready = (q.st == udb_pkg::DS_LOAD) && tick_hit && !paused && !stop_seen;
    assign busy = (q.st != udb_pkg::DS_IDLE);
    assign words_sent = q.cnt;
    assign link.dmarq = q.dmarq;
    assign link.dstrobe = q.strobe;
    assign link.dev_dd = q.dd;
    assign link.dev_dd_oe_n = q.oe_n;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        // Three-stage input capture; a change counts when stages agree
        d.s1 = {link.dmack_n, link.stop, link.hdmardy_n};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.f = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.f);
        // Strobe pacing divider
        if (tick_hit)
        begin
            d.tick = udb_pkg::TICK_CNT - 4'h1;
        end
        else
        begin
            d.tick = q.tick - 4'h1;
        end
        case (q.st)
            udb_pkg::DS_IDLE:
            begin
                d.strobe = udb_pkg::STRB_RST;
                d.oe_n = 1'b1;
                if (start)
                begin
                    d.dmarq = 1'b1;
                    d.cnt = 8'h00;
                    d.st = udb_pkg::DS_REQ;
                end
            end
            udb_pkg::DS_REQ:
            begin
                if (ack_seen)
                begin
                    d.st = udb_pkg::DS_ACKD;
                end
            end
            udb_pkg::DS_ACKD:
            begin
                // Only stop negated with ready asserted opens the bus
                if (!ack_seen)
                begin
                    d.dmarq = 1'b0;
                    d.st = udb_pkg::DS_END;
                end
                else if (!stop_seen && !paused)
                begin
                    d.oe_n = 1'b0;
                    d.tick = 4'h0;
                    d.pend = 1'b0;
                    d.st = udb_pkg::DS_LOAD;
                end
            end
            udb_pkg::DS_LOAD:
            begin
                if (stop_seen)
                begin
                    d.dmarq = 1'b0;
                    d.oe_n = 1'b1;
                    d.st = udb_pkg::DS_END;
                end
                else if (paused)
                begin
                    d.st = udb_pkg::DS_PAUSE;
                end
                else if (tick_hit && tx_valid)
                begin
                    d.dd = tx_data;
                    d.last = tx_last;
                    d.pend = 1'b1;
                    d.st = udb_pkg::DS_EDGE;
                end
            end
            udb_pkg::DS_EDGE:
            begin
                if (stop_seen)
                begin
                    d.dmarq = 1'b0;
                    d.oe_n = 1'b1;
                    d.st = udb_pkg::DS_END;
                end
                else if (paused)
                begin
                    // Scheduled edge is put off until the host resumes
                    d.st = udb_pkg::DS_PAUSE;
                end
                else if (tick_hit)
                begin
                    d.strobe = !q.strobe;
                    d.pend = 1'b0;
                    d.cnt = q.cnt + 8'h01;
                    if (q.last)
                    begin
                        // Last word held one more cycle past its edge; END then lets go
                        d.st = udb_pkg::DS_END;
                    end
                    else
                    begin
                        d.st = udb_pkg::DS_LOAD;
                    end
                end
            end
            udb_pkg::DS_PAUSE:
            begin
                // Strobe held at its level; resume where the word stood
                d.tick = udb_pkg::TICK_CNT - 4'h1;
                if (stop_seen)
                begin
                    d.dmarq = 1'b0;
                    d.oe_n = 1'b1;
                    d.st = udb_pkg::DS_END;
                end
                else if (!paused)
                begin
                    d.st = q.pend ? udb_pkg::DS_EDGE : udb_pkg::DS_LOAD;
                end
            end
            udb_pkg::DS_END:
            begin
                // Request drop and bus release on the same edge
                d.dmarq = 1'b0;
                d.oe_n = 1'b1;
                // Strobe stays put until the host drops acknowledge
                if (!ack_seen)
                begin
                    d.st = udb_pkg::DS_IDLE;
                end
            end
            default:
            begin
                d.st = udb_pkg::DS_IDLE;
                d.dmarq = 1'b0;
                d.oe_n = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q.st <= udb_pkg::DS_IDLE;
            q.s1 <= 3'h7;
            q.s2 <= 3'h7;
            q.s3 <= 3'h7;
            q.f <= 3'h7;
            q.tick <= 4'h0;
            q.dmarq <= 1'b0;
            q.strobe <= udb_pkg::STRB_RST;
            q.oe_n <= 1'b1;
            q.dd <= udb_pkg::BUS_IDLE;
            q.pend <= 1'b0;
            q.last <= 1'b0;
            q.cnt <= 8'h00;
        end
        else
        begin
            q <= d;
        end
    end

endmodule : udb_dev

// ===== rtl/udb_host.sv
// Host end of a data-in burst: acknowledges, paces control, receives words.
// Assumes the device end on the far side of udb_if and a 10 MHz core clock.
`timescale 1ns/1ps
module udb_host (
    input wire logic core_clk,
    input wire logic reset_n,
    udb_if.host link,
    input wire logic rd_go,
    input wire logic rx_ready,
    input wire logic rd_stop,
    input wire logic [udb_pkg::DW-1:0] crc_word,
    output logic [udb_pkg::DW-1:0] rx_data,
    output logic rx_valid,
    output logic done,
    output logic busy
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam int SW = udb_pkg::DW + 2;

    typedef struct packed {
        udb_pkg::udb_host_st_t st;
        logic [SW-1:0] s1;
        logic [SW-1:0] s2;
        logic [SW-1:0] s3;
        logic [SW-1:0] f;
        logic [3:0] cnt;
        logic dmack_n;
        logic stop;
        logic hdmardy_n;
        logic oe_n;
        logic [udb_pkg::DW-1:0] dd;
        logic prev_strb;
        logic [udb_pkg::DW-1:0] rdata;
        logic rvalid;
        logic done;
    } udb_host_state_t;

    udb_host_state_t q;
    udb_host_state_t d;

    // Filtered device lines: top request, next strobe, then data
    logic req_seen;
    logic strb;
    logic [udb_pkg::DW-1:0] bus;
    logic strb_edge;

    assign req_seen = q.f[SW-1];
    assign strb = q.f[SW-2];
    assign bus = q.f[udb_pkg::DW-1:0];
    assign strb_edge = (strb != q.prev_strb);

    assign link.dmack_n = q.dmack_n;
    assign link.stop = q.stop;
    assign link.hdmardy_n = q.hdmardy_n;
    assign link.host_dd = q.dd;
    assign link.host_dd_oe_n = q.oe_n;
    assign rx_data = q.rdata;
    assign rx_valid = q.rvalid;
    assign done = q.done;
    assign busy = (q.st != udb_pkg::HS_IDLE);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.s1 = {link.dmarq, link.dstrobe, link.dd};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.f = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.f);
        d.rvalid = 1'b0;
        d.done = 1'b0;
        d.prev_strb = strb;
        // Words are taken on every strobe edge while the burst is open
        if (strb_edge && (q.st == udb_pkg::HS_RECV || q.st == udb_pkg::HS_TERM))
        begin
            d.rdata = bus;
            d.rvalid = 1'b1;
        end
        case (q.st)
            udb_pkg::HS_IDLE:
            begin
                d.prev_strb = udb_pkg::STRB_RST;
                // No limit on how long a request may wait
                if (rd_go && req_seen)
                begin
                    d.dmack_n = 1'b0;
                    d.oe_n = 1'b1;
                    d.cnt = udb_pkg::ENV_CNT;
                    d.st = udb_pkg::HS_ENV;
                end
            end
            udb_pkg::HS_ENV:
            begin
                // Counted envelope before stop and ready change
                if (q.cnt <= 4'h1)
                begin
                    d.stop = 1'b0;
                    d.hdmardy_n = 1'b0;
                    d.st = udb_pkg::HS_RECV;
                end
                else
                begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            udb_pkg::HS_RECV:
            begin
                d.hdmardy_n = !rx_ready;
                if (!req_seen)
                begin
                    d.stop = 1'b1;
                    d.hdmardy_n = 1'b1;
                    d.cnt = udb_pkg::ZAH_CNT;
                    d.st = udb_pkg::HS_ZAH;
                end
                else if (rd_stop)
                begin
                    d.stop = 1'b1;
                    d.st = udb_pkg::HS_TERM;
                end
            end
            udb_pkg::HS_TERM:
            begin
                d.hdmardy_n = 1'b1;
                if (!req_seen)
                begin
                    d.cnt = udb_pkg::ZAH_CNT;
                    d.st = udb_pkg::HS_ZAH;
                end
            end
            udb_pkg::HS_ZAH:
            begin
                // Device may still be letting go of the bus
                if (q.cnt <= 4'h1)
                begin
                    d.oe_n = 1'b0;
                    d.dd = crc_word;
                    d.st = udb_pkg::HS_CRC;
                end
                else
                begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            udb_pkg::HS_CRC:
            begin
                // Stop and ready already at burst-end levels here
                d.dmack_n = 1'b1;
                d.st = udb_pkg::HS_REL;
            end
            udb_pkg::HS_REL:
            begin
                d.dd = udb_pkg::BUS_IDLE;
                d.done = 1'b1;
                d.st = udb_pkg::HS_IDLE;
            end
            default:
            begin
                d.st = udb_pkg::HS_IDLE;
                d.dmack_n = 1'b1;
                d.stop = 1'b1;
                d.hdmardy_n = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q.st <= udb_pkg::HS_IDLE;
            q.s1 <= '0;
            q.s2 <= '0;
            q.s3 <= '0;
            q.f <= '0;
            q.cnt <= 4'h0;
            q.dmack_n <= 1'b1;
            q.stop <= 1'b1;
            q.hdmardy_n <= 1'b1;
            q.oe_n <= 1'b0;
            q.dd <= udb_pkg::BUS_IDLE;
            q.prev_strb <= udb_pkg::STRB_RST;
            q.rdata <= udb_pkg::BUS_IDLE;
            q.rvalid <= 1'b0;
            q.done <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

endmodule : udb_host

// ===== sim/udb_checker.sv
// Concurrent checks on the link wires between the host and device ends.
// Assumes one core clock and reset for both ends; the bench instantiates it.
`timescale 1ns/1ps
module udb_checker (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic dmarq,
    input wire logic dmack_n,
    input wire logic stop,
    input wire logic hdmardy_n,
    input wire logic dstrobe,
    input wire logic host_dd_oe_n,
    input wire logic dev_dd_oe_n
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic strb_q;
    logic [1:0] late_q;

    // Strobe edges seen since the host withdrew ready
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            strb_q <= udb_pkg::STRB_RST;
            late_q <= 2'h0;
        end
        else
        begin
            strb_q <= dstrobe;
            if (!hdmardy_n)
                late_q <= 2'h0;
            else if (dmarq && (dstrobe != strb_q) && (late_q != 2'h3))
                late_q <= late_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence ack_start;
        $fell(dmack_n);
    endsequence
    sequence env_step;
        (stop && hdmardy_n) ##1 (!stop && !hdmardy_n);
    endsequence
    sequence ready_held;
        (!stop && !hdmardy_n && !dmack_n && dmarq) [*8];
    endsequence
    sequence paused_held;
        (hdmardy_n && !dmack_n && dmarq) [*8];
    endsequence

    a_no_bus_fight: assert property (host_dd_oe_n || dev_dd_oe_n)
        else $error("both ends drive the data bus");
    a_host_release_ack: assert property (ack_start |-> host_dd_oe_n)
        else $error("host still drives bus at acknowledge");
    a_dev_float_end: assert property ($fell(dmarq) |-> dev_dd_oe_n)
        else $error("device drives bus after request drop");
    a_crc_wait_gap: assert property ($fell(dmarq) && !dmack_n |-> host_dd_oe_n [*2])
        else $error("host drives crc too early");
    a_drive_qualified: assert property ($fell(dev_dd_oe_n) |-> $past(!stop && !hdmardy_n, 4)
        && dstrobe)
        else $error("device drove bus without qualified host");
    a_env_step_count: assert property (ack_start |-> env_step)
        else $error("control change not one cycle after acknowledge");
    a_ack_after_req: assert property (ack_start |-> dmarq)
        else $error("acknowledge without request");
    a_pause_one_more: assert property (late_q <= 2'h1)
        else $error("more than one strobe edge after pause");
    a_pause_holds_strb: assert property (paused_held |-> $stable(dstrobe))
        else $error("strobe moved while paused");
    a_end_ctrl_settled: assert property ($rose(dmack_n) |-> stop && hdmardy_n && !dmarq
        && dev_dd_oe_n)
        else $error("control lines unsettled at acknowledge release");
    a_first_word_time: assert property (ready_held |-> !dev_dd_oe_n)
        else $error("first word not driven in time");
endmodule : udb_checker

// ===== sim/test_ultra_dma_burst_handshake.sv
// Self-checking bench: host and device ends on one link, plus a second
// device end facing a scripted host that changes one line per step, except the last step, which releases acknowledge and ready together.
// Assumes the design files and udb_checker are compiled first.
`timescale 1ns/1ps
module test_ultra_dma_burst_handshake;
    logic core_clk, reset_n, start, start_b, tx_valid, tx_last, tx_ready, dev_busy, busy_b;
    logic rd_go, rx_ready, rd_stop, rx_valid, done, host_busy, mix_ready;
    logic [15:0] tx_data, crc_word, rx_data, crc_seen, strb_q;
    logic [7:0] words_sent;
    logic [15:0] sent_q[$];
    logic [15:0] got_q[$];
    int n_fail, samples_checked, n_done, edges, stop_lim, hold_cnt, i;

    udb_if lk();
    udb_if lk2();
    udb_dev u_udb_dev (.core_clk(core_clk), .reset_n(reset_n), .link(lk.dev), .start(start),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .busy(dev_busy), .words_sent(words_sent));
    udb_dev u_udb_dev_b (.core_clk(core_clk), .reset_n(reset_n), .link(lk2.dev),
        .start(start_b), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_ready(), .busy(busy_b), .words_sent());
    udb_host u_udb_host (.core_clk(core_clk), .reset_n(reset_n), .link(lk.host), .rd_go(rd_go),
        .rx_ready(rx_ready), .rd_stop(rd_stop), .crc_word(crc_word), .rx_data(rx_data),
        .rx_valid(rx_valid), .done(done), .busy(host_busy));
    udb_checker u_udb_checker (.core_clk(core_clk), .reset_n(reset_n), .dmarq(lk.dmarq),
        .dmack_n(lk.dmack_n), .stop(lk.stop), .hdmardy_n(lk.hdmardy_n), .dstrobe(lk.dstrobe),
        .host_dd_oe_n(lk.host_dd_oe_n), .dev_dd_oe_n(lk.dev_dd_oe_n));

    // Core clock
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Receive side pacing and host stop request
    always @(posedge core_clk)
    begin
        if (hold_cnt == 0)
        begin
            rx_ready <= !mix_ready || ($urandom % 2 == 0);
            hold_cnt <= $urandom % 14;
        end
        else
            hold_cnt <= hold_cnt - 1;
        rd_stop <= (stop_lim > 0) && (got_q.size() >= stop_lim) && (n_done == 0);
    end

    // Link and user-side monitor
    always @(negedge core_clk)
    begin
        if (rx_valid === 1'b1) got_q.push_back(rx_data);
        if (done === 1'b1) n_done++;
        if (lk.host_dd_oe_n === 1'b0 && lk.dmack_n === 1'b0) crc_seen = lk.dd;
        if (lk.dmack_n === 1'b0 && lk.dstrobe !== strb_q[0]) edges++;
        strb_q[0] = lk.dstrobe;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic conclude();
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    function automatic logic [31:0] exp_count(input int n);
        return 32'(n % 256);
    endfunction : exp_count

    task automatic burst(input int n, input int stop_at);
        int k;
        int t;
        logic [15:0] w;
        logic [15:0] c;
        sent_q.delete();
        got_q.delete();
        stop_lim = stop_at;
        n_done = 0;
        edges = 0;
        c = 16'($urandom);
        crc_seen = ~c;
        @(posedge core_clk);
        crc_word <= c;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        for (k = 0; k < n; k++)
        begin
            w = (k == 0) ? 16'hFFFF : ((k == 1) ? 16'h0000 : 16'($urandom));
            tx_data <= w;
            tx_valid <= 1'b1;
            tx_last <= (k == n - 1);
            for (t = 0; t < 400 && tx_ready !== 1'b1 && n_done == 0; t++)
                @(negedge core_clk);
            if (n_done > 0)
                break;
            if (t == 400)
            begin
                check(32'h0, 32'h1, "word accept timeout");
                conclude();
            end
            @(posedge core_clk);
            sent_q.push_back(w);
            tx_valid <= 1'b0;
            repeat ($urandom % 3 + 1) @(posedge core_clk);
        end
        for (t = 0; t < 3000 && n_done == 0; t++)
            @(negedge core_clk);
        if (n_done == 0)
        begin
            check(32'h0, 32'h1, "burst end timeout");
            conclude();
        end
        stop_lim = 0;
        check(32'(got_q.size()), 32'(words_sent), "words received");
        check(32'(edges), 32'(words_sent), "strobe edges");
        for (k = 0; k < got_q.size() && k < sent_q.size(); k++)
            check(32'(got_q[k]), 32'(sent_q[k]), "data word");
        if (stop_at == 0)
            check(32'(words_sent), exp_count(n), "burst length");
        check(32'(crc_seen), 32'(c), "crc word");
        repeat (12) @(negedge core_clk);
        check(32'(dev_busy), 32'h0, "device idle");
        check(32'(host_busy), 32'h0, "host idle");
    endtask : burst

    task automatic rogue_step(input int which);
        @(posedge core_clk);
        if (which == 0) lk2.dmack_n <= 1'b0;
        if (which == 1) lk2.stop <= 1'b0;
        if (which == 2) lk2.hdmardy_n <= 1'b0;
        if (which == 3) lk2.stop <= 1'b1;
        if (which == 4) lk2.dmack_n <= 1'b1;
        if (which == 4) lk2.hdmardy_n <= 1'b1;
        repeat (12) @(negedge core_clk);
    endtask : rogue_step

    initial
    begin
        reset_n = 1'b0;
        {start, start_b, tx_valid, tx_last, rd_stop, mix_ready} = 6'h00;
        {rd_go, rx_ready} = 2'h3;
        tx_data = 16'h0000;
        crc_word = 16'h0000;
        strb_q = 16'h0001;
        {n_fail, samples_checked, n_done, edges, stop_lim, hold_cnt} = {6{32'h0}};
        {lk2.dmack_n, lk2.stop, lk2.hdmardy_n, lk2.host_dd_oe_n} = 4'hF;
        lk2.host_dd = 16'h0000;
        void'($urandom(98745));
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        burst(1, 0);
        mix_ready <= 1'b1;
        for (i = 0; i < 5; i++)
            burst(2 + $urandom % 6, 0);
        @(posedge core_clk);
        rd_go <= 1'b0;
        fork
            burst(3, 0);
            begin
                repeat (40) @(negedge core_clk);
                check(32'(lk.dmack_n), 32'h1, "acknowledge held off");
                @(posedge core_clk);
                rd_go <= 1'b1;
            end
        join
        burst(200, 3);
        @(posedge core_clk);
        start_b <= 1'b1;
        @(posedge core_clk);
        start_b <= 1'b0;
        repeat (8) @(negedge core_clk);
        check(32'(lk2.dmarq), 32'h1, "request raised");
        rogue_step(0);
        check(32'(lk2.dev_dd_oe_n), 32'h1, "drive on acknowledge alone");
        rogue_step(1);
        check(32'(lk2.dev_dd_oe_n), 32'h1, "drive with ready withheld");
        rogue_step(2);
        check(32'(lk2.dev_dd_oe_n), 32'h0, "drive once qualified");
        rogue_step(3);
        check(32'({lk2.dmarq, lk2.dev_dd_oe_n}), 32'h1, "float on stop");
        rogue_step(4);
        check(32'(busy_b), 32'h0, "idle after release");
        conclude();
    end
endmodule : test_ultra_dma_burst_handshake
